// file: rtl/vip_pkg.sv
// Package for the vectored interrupt priority block: request numbering,
// vector table layout, level encoding and source bundle types.
// Assumes a single machine clock domain and a CPU core on the far side.
package vip_pkg;

  // Request numbering
  localparam int unsigned NUM_REQ = 24;
  localparam int unsigned REQ_W = 5;
  localparam int unsigned LVL_W = 2;

  // Vector table: request 0 at the top pair, each next pair two bytes lower
  localparam logic [15:0] VEC_TOP_UPPER = 16'hfffa;
  localparam logic [15:0] VEC_STEP = 16'h0002;

  // Level encoding: 0 highest, 2 lowest usable, 3 means no interruption
  localparam logic [1:0] LVL_HIGHEST = 2'h0;
  localparam logic [1:0] LVL_LOWEST = 2'h2;
  localparam logic [1:0] LVL_NONE = 2'h3;
  localparam logic [1:0] LVL_RESET = 2'h3;

  // Request number assignment
  localparam int unsigned REQ_UART_SIO = 4;
  localparam int unsigned REQ_CT0_LO = 5;
  localparam int unsigned REQ_CT0_HI = 6;
  localparam int unsigned REQ_LIN_RX = 7;
  localparam int unsigned REQ_LIN_TX = 8;
  localparam int unsigned REQ_PG1_LO = 9;
  localparam int unsigned REQ_PG1_HI = 10;
  localparam int unsigned REQ_UNUSED_A = 11;
  localparam int unsigned REQ_PG0_HI = 12;
  localparam int unsigned REQ_PG0_LO = 13;
  localparam int unsigned REQ_CT1_HI = 14;
  localparam int unsigned REQ_PG16 = 15;
  localparam int unsigned REQ_UNUSED_B = 16;
  localparam int unsigned REQ_UNUSED_C = 17;
  localparam int unsigned REQ_ADC = 18;
  localparam int unsigned REQ_TBT = 19;
  localparam int unsigned REQ_WATCH = 20;
  localparam int unsigned REQ_UNUSED_D = 21;
  localparam int unsigned REQ_CT1_LO = 22;
  localparam int unsigned REQ_FLASH = 23;

  // Peripheral source flags, each a level held until software clears it
  typedef struct packed {
    logic [7:0] ext;
    logic uart_sio;
    logic ct0_lo;
    logic ct0_hi;
    logic lin_rx;
    logic lin_tx;
    logic pg1_lo;
    logic pg1_hi;
    logic pg0_hi;
    logic pg0_lo;
    logic ct1_hi;
    logic pg16;
    logic adc;
    logic tbt;
    logic watch;
    logic ct1_lo;
    logic flash;
  } vip_src_t;

  // Request presented to the CPU core
  typedef struct packed {
    logic valid;
    logic [4:0] num;
    logic [1:0] level;
    logic [15:0] vec_upper;
    logic [15:0] vec_lower;
  } vip_req_t;

endpackage

// file: rtl/vip_rank.sv
// Pairwise ranking stage: picks the better of two candidate requests.
// Assumes combinational use inside the selection chain of vip_top.
`timescale 1ns/1ns
`default_nettype none

module vip_rank
(
  // Candidate a, always the lower request number
  input wire logic i_a_valid,
  input wire logic [4:0] i_a_num,
  input wire logic [1:0] i_a_level,
  // Candidate b
  input wire logic i_b_valid,
  input wire logic [4:0] i_b_num,
  input wire logic [1:0] i_b_level,
  // Winner
  output logic o_valid,
  output logic [4:0] o_num,
  output logic [1:0] o_level
);

  // On equal level a wins, so lower numbers rank first
  wire logic pick_b;
  assign pick_b = i_b_valid & (~i_a_valid | (i_b_level < i_a_level)); // [RL3] [RL8]
  assign o_valid = i_a_valid | i_b_valid;
  assign o_num = pick_b ? i_b_num : i_a_num;
  assign o_level = pick_b ? i_b_level : i_a_level;

endmodule // vip_rank

`default_nettype wire

// file: rtl/vip_top.sv
// Vectored interrupt request gathering and priority selection.
// Assumes the CPU core holds the enable flag and current level itself
// and fetches the vector presented here; all inputs are synchronous.
// Outputs are registered, so the request lags its sources by one edge.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RL1: 24 requests, vectors stepping down two bytes
// RL2: Each request has its own 2-bit level
// RL3: Equal level: lowest request number wins
// RL4: Timer 0 halves request 5 and 6
// RL5: Pulse generators on requests 9,10,12,13
// RL6: Timer 1 on 14/22; 11,16,17,21 unused
// RL7: Core takes only enabled, higher-priority requests
// RL8: Level 0 highest, 3 none, enable reset-cleared
// RL9: Request follows source flag until cleared
module vip_top
  import vip_pkg::*;
#(
  parameter int unsigned N_REQ = vip_pkg::NUM_REQ
)
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Peripheral source flags
  input wire vip_pkg::vip_src_t i_src,
  // Level fields, request k at bits 2k+1:2k
  input wire logic [2*vip_pkg::NUM_REQ-1:0] i_request_level_field,
  // Best pending request toward the core
  output vip_pkg::vip_req_t o_req,
  // Raw request lines, for visibility
  output logic [vip_pkg::NUM_REQ-1:0] o_req_lines
);
  import vip_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Request line mapping; lines follow the source flags as levels
  wire logic [NUM_REQ-1:0] lines;
  // External channels n and n+4 share request n; either flag raises it
  assign lines[0] = i_src.ext[0] | i_src.ext[4]; // [RL1]
  assign lines[1] = i_src.ext[1] | i_src.ext[5]; // [RL1]
  assign lines[2] = i_src.ext[2] | i_src.ext[6]; // [RL1]
  assign lines[3] = i_src.ext[3] | i_src.ext[7]; // [RL1]
  assign lines[REQ_UART_SIO] = i_src.uart_sio;
  assign lines[REQ_CT0_LO] = i_src.ct0_lo; // [RL4]
  assign lines[REQ_CT0_HI] = i_src.ct0_hi; // [RL4]
  assign lines[REQ_LIN_RX] = i_src.lin_rx;
  assign lines[REQ_LIN_TX] = i_src.lin_tx;
  assign lines[REQ_PG1_LO] = i_src.pg1_lo; // [RL5]
  assign lines[REQ_PG1_HI] = i_src.pg1_hi; // [RL5]
  assign lines[REQ_UNUSED_A] = 1'b0; // [RL6]
  assign lines[REQ_PG0_HI] = i_src.pg0_hi; // [RL5]
  assign lines[REQ_PG0_LO] = i_src.pg0_lo; // [RL5]
  assign lines[REQ_CT1_HI] = i_src.ct1_hi; // [RL6]
  assign lines[REQ_PG16] = i_src.pg16;
  assign lines[REQ_UNUSED_B] = 1'b0; // [RL6]
  assign lines[REQ_UNUSED_C] = 1'b0; // [RL6]
  assign lines[REQ_ADC] = i_src.adc;
  assign lines[REQ_TBT] = i_src.tbt;
  assign lines[REQ_WATCH] = i_src.watch;
  assign lines[REQ_UNUSED_D] = 1'b0; // [RL6]
  assign lines[REQ_CT1_LO] = i_src.ct1_lo; // [RL6]
  assign lines[REQ_FLASH] = i_src.flash;

  //////////////////////////////////////////////////////////////////////////
  // Selection chain; a line at level 3 can never interrupt, so it is
  // dropped here rather than left for the core to filter
  wire logic [NUM_REQ:0] ch_valid;
  wire logic [REQ_W-1:0] ch_num [NUM_REQ+1];
  wire logic [LVL_W-1:0] ch_level [NUM_REQ+1];
  assign ch_valid[0] = 1'b0;
  assign ch_num[0] = 5'h00;
  assign ch_level[0] = LVL_NONE;

  genvar g;
  generate
    for (g = 0; g < NUM_REQ; g++)
    begin : g_rank
      wire logic [LVL_W-1:0] lvl;
      wire logic live;
      assign lvl = i_request_level_field[2*g+1:2*g]; // [RL2]
      assign live = lines[g] & (lvl != LVL_NONE); // [RL8]
      vip_rank u_rank
      (
        .i_a_valid(ch_valid[g]),
        .i_a_num(ch_num[g]),
        .i_a_level(ch_level[g]),
        .i_b_valid(live),
        .i_b_num(5'(g)),
        .i_b_level(lvl),
        .o_valid(ch_valid[g+1]),
        .o_num(ch_num[g+1]),
        .o_level(ch_level[g+1])
      );

      // No live line may hold a better level than the winner, nor an
      // equal level at a lower number
      lvl_beat_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL8]
        live |-> ch_level[NUM_REQ] <= lvl)
        else $error("better level lost in selection");
      tie_low_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL3]
        (live && ch_level[NUM_REQ] == lvl) |-> ch_num[NUM_REQ] <= 5'(g))
        else $error("equal level not won by lowest number");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Vector address of the winner
  // The step of two is a shift, so only one subtractor is built
  wire logic [15:0] vec_up;
  assign vec_up = 16'(VEC_TOP_UPPER - 16'(ch_num[NUM_REQ]) * VEC_STEP); // [RL1]

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs; the core applies its own enable and level gate
  vip_req_t req_d;
  vip_req_t req_q;
  logic [NUM_REQ-1:0] lines_q;
  assign req_d.valid = ch_valid[NUM_REQ];
  assign req_d.num = ch_num[NUM_REQ];
  // An idle output shows level 3, so a core comparing levels alone stays idle
  assign req_d.level = ch_valid[NUM_REQ] ? ch_level[NUM_REQ] : LVL_NONE;
  assign req_d.vec_upper = vec_up;
  assign req_d.vec_lower = 16'(vec_up + 16'h0001);

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      // Reset shows the same idle request as an empty chain, so the vector
      // pair is consistent from the first edge onward
      req_q.valid <= 1'b0;
      req_q.num <= 5'h00;
      req_q.level <= LVL_RESET;
      req_q.vec_upper <= VEC_TOP_UPPER;
      req_q.vec_lower <= 16'(VEC_TOP_UPPER + 16'h0001);
      lines_q <= '0;
    end
    else
    begin
      req_q <= req_d;
      lines_q <= lines; // [RL9]
    end
  end

  assign o_req = req_q;
  assign o_req_lines = lines_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks: unused, external 0, serial, timer and pulse generator numbers carry their own sources
  // Unused numbers must stay quiet even with every source set
  unused_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL6]
    !(o_req_lines[11] | o_req_lines[16] | o_req_lines[17] | o_req_lines[21]))
    else $error("unused request asserted");
  ext_share_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL1]
    i_src.ext[4] |=> o_req_lines[0])
    else $error("external channel 4 not on request 0");
  serial_map_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL1]
    (i_src.lin_rx && !i_src.lin_tx) |=> (o_req_lines[REQ_LIN_RX] && !o_req_lines[REQ_LIN_TX]))
    else $error("serial receive mapping wrong");
  // Swapped halves would pass a plain set test, so the four checks after
  // line_follow_a hold the partner half low
  line_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL4]
    i_src.ct0_hi |=> o_req_lines[6])
    else $error("timer 0 upper not on request 6");
  ct0_map_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL4]
    (i_src.ct0_lo && !i_src.ct0_hi) |=> (o_req_lines[REQ_CT0_LO] && !o_req_lines[REQ_CT0_HI]))
    else $error("timer 0 lower mapping wrong");
  pg_map_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL5]
    (i_src.pg0_hi && !i_src.pg0_lo) |=> (o_req_lines[12] && !o_req_lines[13]))
    else $error("pulse generator 0 mapping wrong");
  pg1_map_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL5]
    (i_src.pg1_lo && !i_src.pg1_hi) |=> (o_req_lines[REQ_PG1_LO] && !o_req_lines[REQ_PG1_HI]))
    else $error("pulse generator 1 mapping wrong");
  ct1_map_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL6]
    (i_src.ct1_hi && !i_src.ct1_lo) |=> (o_req_lines[REQ_CT1_HI] && !o_req_lines[REQ_CT1_LO]))
    else $error("timer 1 mapping wrong");
  // Lines are levels: they follow the flags and nothing else
  drop_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL9]
    $fell(o_req_lines[REQ_FLASH]) |-> !$past(i_src.flash))
    else $error("line dropped while source set");
  idle_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL9]
    (lines == '0) |=> !o_req.valid)
    else $error("request presented with no line set");
  win_live_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL9]
    o_req.valid |-> o_req_lines[o_req.num])
    else $error("presented request has no line");

  //////////////////////////////////////////////////////////////////////////
  // Checks: vector pair of the presented request
  vec_map_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL1]
    o_req.valid |-> o_req.vec_upper == 16'(VEC_TOP_UPPER - 16'(o_req.num) * VEC_STEP))
    else $error("vector address wrong");
  lower_byte_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL1]
    o_req.vec_lower == 16'(o_req.vec_upper + 16'h0001))
    else $error("vector lower byte wrong");

  //////////////////////////////////////////////////////////////////////////
  // Checks: level encoding and equal-level order
  level_none_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL8]
    o_req.valid |-> o_req.level != LVL_NONE)
    else $error("level 3 presented");
  none_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL8]
    !o_req.valid |-> o_req.level == LVL_NONE)
    else $error("idle request not at level 3");
  mask_all_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL8]
    (&i_request_level_field) |=> !o_req.valid)
    else $error("request presented with all levels at 3");
  valid_any_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL9]
    o_req.valid |-> $past(|lines))
    else $error("request presented without a pending line");
  level_copy_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL2]
    o_req.valid |-> o_req.level == $past(i_request_level_field[2*req_d.num +: 2]))
    else $error("level not taken from own field");
  // A request at the best level with its higher neighbour pending at the
  // same level must win outright
  tie_order_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [RL3]
    (lines[0] && lines[1] && i_request_level_field[1:0] == LVL_HIGHEST
     && i_request_level_field[3:2] == LVL_HIGHEST) |=> o_req.num == 5'h00)
    else $error("tie not won by lowest number");

endmodule // vip_top

`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for vip_top with the core model on its request side.
// Assumes registered outputs one edge after the inputs, inputs driven at negedge.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import vip_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  vip_src_t src = '0;
  logic [47:0] lvl = '1;
  logic ie = 1'b0;
  logic [1:0] cur = 2'h3;
  vip_req_t req;
  logic [23:0] lines;
  logic take;
  logic [15:0] vec;
  logic [31:0] rnd = 32'h757cd4d4;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #50 i_core_clk = ~i_core_clk;

  vip_top dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_src(src),
    .i_request_level_field(lvl), .o_req(req), .o_req_lines(lines));
  vip_core_model core (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ie(ie),
    .i_cur_level(cur), .i_req(req), .o_take(take), .o_vec(vec));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Source flags to request numbers; unused numbers stay zero
  function automatic logic [23:0] exp_lines(input vip_src_t s);
    return {s.flash, s.ct1_lo, 1'b0, s.watch, s.tbt, s.adc, 2'b00, s.pg16, s.ct1_hi,
      s.pg0_lo, s.pg0_hi, 1'b0, s.pg1_hi, s.pg1_lo, s.lin_tx, s.lin_rx, s.ct0_hi,
      s.ct0_lo, s.uart_sio, s.ext[7:4] | s.ext[3:0]};
  endfunction

  // Scan downward with <= so the lowest number wins a tie
  function automatic vip_req_t exp_req(input logic [23:0] l, input logic [47:0] f);
    vip_req_t r;
    r = '0;
    r.level = 2'h3;
    r.vec_upper = 16'hfffa;
    r.vec_lower = 16'hfffb;
    for (int k = 23; k >= 0; k--)
    begin
      if (l[k] && f[2*k +: 2] != 2'h3 && f[2*k +: 2] <= r.level)
      begin
        r.valid = 1'b1;
        r.num = 5'(k);
        r.level = f[2*k +: 2];
        r.vec_upper = 16'hfffa - 16'(2 * k);
        r.vec_lower = 16'hfffb - 16'(2 * k);
      end
    end
    return r;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Compare what the last inputs produced, then apply the next ones
  task automatic step(input vip_src_t s, input logic [47:0] f);
    vip_req_t r;
    logic hit;
    @(negedge i_core_clk);
    r = exp_req(exp_lines(src), lvl);
    hit = ie && r.valid && r.level < cur;
    check(64'(req), 64'(r));
    check(64'(lines), 64'(exp_lines(src)));
    check(64'(take), 64'(hit));
    check(64'(vec), 64'(hit ? r.vec_upper : 16'h0000));
    src = s;
    lvl = f;
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: corner cases first, then seeded random traffic
  initial
  begin
    repeat (3) @(negedge i_core_clk);
    // Held in reset: idle request, no lines, nothing taken
    check(64'(req), 64'(exp_req(24'h0, '1)));
    check(64'(lines), 64'h0);
    check(64'(take), 64'h0);
    i_resetn = 1'b1;
    // One flag at a time, then ties, all masked, a late winner, all cleared
    for (int b = 0; b < 23; b++)
      step(vip_src_t'(23'h1 << b), 48'h0);
    step('1, {24{2'h1}});
    step('1, '1);
    step('1, {2'h0, {23{2'h2}}});
    step('1, '0);
    step('0, '0);
    $display("Test corner done");
    for (int i = 0; i < 300; i++)
    begin
      rnd = lfsr(rnd);
      cur = rnd[1:0];
      ie = rnd[2];
      step(vip_src_t'(23'(rnd[31:9] & lfsr(rnd))), {rnd[15:0], lfsr(rnd)});
      rnd = lfsr(rnd);
    end
    step('0, '1);
    $display("Test random done");
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire

// file: tb/vip_core_model.sv
// CPU core stand-in: holds the enable flag and takes the request presented.
// Assumes vip_top drives a registered request on the same machine clock.
`timescale 1ns/1ns
`default_nettype none

module vip_core_model
  import vip_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Enable flag request, current level and presented request
  input wire logic i_ie,
  input wire logic [1:0] i_cur_level,
  input wire vip_pkg::vip_req_t i_req,
  // Acceptance
  output logic o_take,
  output logic [15:0] o_vec
);
  import vip_pkg::*;

  logic ie_q;

  // Flag is cleared by reset so nothing is taken before software allows it
  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
      ie_q <= 1'b0;
    else
      ie_q <= i_ie;
  end

  // Strictly better level only; equal level never preempts
  assign o_take = ie_q && i_req.valid && (i_req.level < i_cur_level);
  assign o_vec = o_take ? i_req.vec_upper : 16'h0000;
endmodule // vip_core_model

`default_nettype wire
